//--- tpio_params.svh
// Purpose: offsets, field positions and reset values of the two-port io
// Assumes: included by bare name
// Notes:   definitions only
`ifndef TPIO_PARAMS_SVH
`define TPIO_PARAMS_SVH
// register byte offsets, one aligned word each
`define TPIO_ADR_CTRL  8'h00
`define TPIO_ADR_ADIR  8'h04
`define TPIO_ADR_BDIR  8'h08
`define TPIO_ADR_HDIR  8'h0c
`define TPIO_ADR_ADAT  8'h10
`define TPIO_ADR_BDAT  8'h14
`define TPIO_ADR_HDAT  8'h18
`define TPIO_ADR_ISTAT 8'h1c
`define TPIO_ADR_IMASK 8'h20
// control byte fields
`define TPIO_CTRL_AMODE 1:0
`define TPIO_CTRL_BMODE 3:2
// reset values: both ports bit-programmable, all lines inputs
`define TPIO_CTRL_RST  4'hf
`define TPIO_MASK_RST  2'h3
// peripheral strobe is active low
`define TPIO_STB_ACTIVE 1'b0
// handshake pin positions
`define TPIO_HS_ARDY 0
`define TPIO_HS_ASTB 1
`define TPIO_HS_BRDY 2
`define TPIO_HS_BSTB 3
`endif

//--- tpio_pkg.sv
// Purpose: shared types of the two-port io
// Assumes: nothing
// Notes:   mode order matches the control field encoding
package tpio_pkg;
  // port mode as stored in the control register
  typedef enum logic [1:0] {MODE_IN, MODE_OUT, MODE_BIDIR, MODE_BITP} tpio_mode_t;
endpackage : tpio_pkg

//--- tpio_hs_if.sv
// Purpose: one ready/strobe channel between the top and its sequencer
// Assumes: all signals on the one system clock
// Notes:   evt is a one-cycle pulse
`timescale 1ns/1ns
interface tpio_hs_if;
  logic enIn;      // channel controls an inbound transfer
  logic enOut;     // channel controls an outbound transfer
  logic stb;       // filtered strobe, high while active
  logic hostDone;  // host read (in) or wrote (out) the data word
  logic rdy;       // ready level for the pin
  logic evt;       // strobe trailing edge while enabled
  modport dev (input enIn, enOut, stb, hostDone, output rdy, evt);
  modport ctl (output enIn, enOut, stb, hostDone, input rdy, evt);
endinterface : tpio_hs_if

//--- tpio_handshake.sv
// Purpose: ready/strobe sequencing for one handshake channel
// Assumes: strobe already synchronised and normalised to active high
// Notes:   data capture itself happens in the top on evt
`timescale 1ns/1ns
module tpio_handshake (
  input wire logic clock,
  input wire logic rst,
  tpio_hs_if.dev   hs
);
  import tpio_pkg::*;

  logic stbPrev_r;   // strobe one cycle ago
  logic enInPrev_r;  // input enable one cycle ago
  logic rdy_r;       // ready level
  logic lead;        // strobe leading edge
  logic trail;       // strobe trailing edge

  assign lead  = hs.stb & ~stbPrev_r;
  assign trail = ~hs.stb & stbPrev_r;

  // strobe history for edge detection
  always_ff @(posedge clock) begin
    if (rst) begin
      stbPrev_r  <= 1'b0;
      enInPrev_r <= 1'b0;
    end else begin
      stbPrev_r  <= hs.stb;
      enInPrev_r <= hs.enIn;
    end
  end

  // ready sequencing; leading edge beats a re-arm in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      rdy_r <= 1'b0;
    end else if (hs.enIn) begin
      if (lead) begin
        rdy_r <= 1'b0;
      end else if (!enInPrev_r || hs.hostDone) begin
        rdy_r <= 1'b1;
      end
    end else if (hs.enOut) begin
      // new data wins over an acknowledge in the same cycle
      if (hs.hostDone) begin
        rdy_r <= 1'b1;
      end else if (trail) begin
        rdy_r <= 1'b0;
      end
    end else begin
      rdy_r <= 1'b0;
    end
  end

  assign hs.rdy = rdy_r;
  assign hs.evt = (hs.enIn | hs.enOut) & trail;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ready_drop_a: assert property (hs.enIn && lead |=> !rdy_r)
    else $error("ready not dropped on strobe leading edge");
  trail_event_a: assert property (
    hs.enIn && $past(hs.stb) && !hs.stb |-> hs.evt)
    else $error("no event on strobe trailing edge");
  out_ready_a: assert property (hs.enOut && hs.hostDone |=> rdy_r)
    else $error("ready not raised after host write");
  idle_low_a: assert property (
    !(hs.enIn || hs.enOut) ##1 !(hs.enIn || hs.enOut) |-> !rdy_r)
    else $error("ready high on an idle channel");
  in_xfer_c: cover property (hs.enIn && lead ##[1:40] hs.evt);
  out_xfer_c: cover property (hs.enOut && hs.hostDone ##[1:40] hs.evt);
endmodule : tpio_handshake

//--- tpio_top.sv
// Purpose: two-port programmable parallel io behind a wishbone slave
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes:   all pin inputs pass a three-stage synchroniser
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "tpio_params.svh"

// What this block does
// - twenty lines: two bytes plus four handshakes
// - answers whether mapped in io or memory
// - each port byte input or output, handshaked
// - only port A may go bidirectional
// - bidir: A pair inbound, B pair outbound
// - bit mode: each data line own direction
// - handshake pair general io when its port is in bit mode, B pair not in bidir
// - strobe leading edge drops ready on an inbound channel, trailing edge on an outbound one
// - strobe trailing edge latches input data, interrupts
module tpio_top #(
  parameter int PW = 8  // port width
) (
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic            clearN,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [7:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  input  wire logic [PW-1:0]   aPinIn,
  output logic      [PW-1:0]   aPinOut,
  output logic      [PW-1:0]   aPinOeN,
  input  wire logic [PW-1:0]   bPinIn,
  output logic      [PW-1:0]   bPinOut,
  output logic      [PW-1:0]   bPinOeN,
  input  wire logic [3:0]      hsPinIn,
  output logic      [3:0]      hsPinOut,
  output logic      [3:0]      hsPinOeN,
  output logic                 intA,
  output logic                 intB,
  output logic                 irq
);
  import tpio_pkg::*;

  localparam int SW = 2*PW + 5;  // synchronised inputs, clear on top
  localparam logic [SW-1:0] SYNC_RST = {1'b1, 4'ha, {(2*PW){1'b0}}}; // idle

  // synchroniser stages and filtered levels
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  logic [SW-1:0] sync3_r;
  logic [SW-1:0] filt_r;
  logic          rstAll;      // reset or clear pin
  logic [PW-1:0] aPin;        // filtered port A
  logic [PW-1:0] bPin;        // filtered port B
  logic [3:0]    hsPin;       // filtered handshake lines

  // bus slave
  logic          ack_r;
  logic [31:0]   dat_r;
  logic [31:0]   rdData;
  logic          req;
  logic          wrEn;
  logic          rdEn;

  // software registers
  logic [3:0]    ctrl_r;      // both mode fields
  logic [PW-1:0] aDir_r;      // 1 = output, bit mode
  logic [PW-1:0] bDir_r;
  logic [3:0]    hsDir_r;     // general-purpose handshake direction
  logic [PW-1:0] aLat_r;      // output latches
  logic [PW-1:0] bLat_r;
  logic [3:0]    hsLat_r;
  logic [PW-1:0] aBuf_r;      // input buffers
  logic [PW-1:0] bBuf_r;
  logic [1:0]    stat_r;      // sticky events, A in bit 0
  logic [1:0]    mask_r;
  logic [1:0]    statClr;

  // pin drivers and interrupt outputs
  logic [PW-1:0] aOut_r;
  logic [PW-1:0] aOeN_r;
  logic [PW-1:0] bOut_r;
  logic [PW-1:0] bOeN_r;
  logic [3:0]    hsOut_r;
  logic [3:0]    hsOeN_r;
  logic          intA_r;
  logic          intB_r;
  logic          irq_r;

  // mode view and channel wiring
  tpio_mode_t    modeA;
  tpio_mode_t    modeB;
  logic          bidir;
  logic          gp0;         // pair A is general io
  logic          gp1;         // pair B is general io
  logic          selA;
  logic          selB;
  logic [1:0]    chEnIn;
  logic [1:0]    chEnOut;
  logic [1:0]    chStb;
  logic [1:0]    chDone;
  logic [1:0]    chRdy;
  logic [1:0]    chEvt;

  tpio_hs_if hs[2] ();

  // three synchroniser flops and a filter flop per pin; a change counts once stages two and three agree
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
      sync3_r <= SYNC_RST;
      filt_r  <= SYNC_RST;
    end else begin
      sync1_r <= {clearN, hsPinIn, bPinIn, aPinIn};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r  <= (sync2_r & sync3_r) | (filt_r & (sync2_r | sync3_r));
    end
  end

  assign rstAll = rst | ~filt_r[SW-1];
  assign aPin   = filt_r[PW-1:0];
  assign bPin   = filt_r[2*PW-1:PW];
  assign hsPin  = filt_r[2*PW+3:2*PW];

  // decode looks at the offset only, so any space mapping works
  assign req  = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wrEn = req & wb_we_i & wb_sel_i[0];
  assign rdEn = req & ~wb_we_i;
  assign selA = wb_adr_i == `TPIO_ADR_ADAT;
  assign selB = wb_adr_i == `TPIO_ADR_BDAT;

  // one ack per request, dropped the cycle after
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= req;
      if (rdEn) begin
        dat_r <= rdData;
      end
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  assign modeA = tpio_mode_t'(ctrl_r[`TPIO_CTRL_AMODE]);
  assign modeB = tpio_mode_t'(ctrl_r[`TPIO_CTRL_BMODE]);
  assign bidir = modeA == MODE_BIDIR;
  assign gp0   = modeA == MODE_BITP;
  assign gp1   = (modeB == MODE_BITP) && !bidir;

  // mode and direction registers; only a control write changes modes
  always_ff @(posedge clock) begin
    if (rstAll) begin
      ctrl_r  <= `TPIO_CTRL_RST;
      aDir_r  <= '0;
      bDir_r  <= '0;
      hsDir_r <= 4'h0;
      mask_r  <= `TPIO_MASK_RST;
    end else if (wrEn) begin
      case (wb_adr_i)
        `TPIO_ADR_CTRL: begin
          ctrl_r[`TPIO_CTRL_AMODE] <= wb_dat_i[1:0];
          // a bidirectional code for port B is ignored
          if (wb_dat_i[3:2] != MODE_BIDIR) begin
            ctrl_r[`TPIO_CTRL_BMODE] <= wb_dat_i[3:2];
          end
        end
        `TPIO_ADR_ADIR:  aDir_r  <= wb_dat_i[PW-1:0];
        `TPIO_ADR_BDIR:  bDir_r  <= wb_dat_i[PW-1:0];
        `TPIO_ADR_HDIR:  hsDir_r <= wb_dat_i[3:0];
        `TPIO_ADR_IMASK: mask_r  <= wb_dat_i[1:0];
        default: begin
          // other offsets hold no mode state
        end
      endcase
    end
  end

  // output latches, written in every mode
  always_ff @(posedge clock) begin
    if (rstAll) begin
      aLat_r  <= '0;
      bLat_r  <= '0;
      hsLat_r <= 4'h0;
    end else if (wrEn) begin
      if (selA) begin
        aLat_r <= wb_dat_i[PW-1:0];
      end
      if (selB) begin
        bLat_r <= wb_dat_i[PW-1:0];
      end
      if (wb_adr_i == `TPIO_ADR_HDAT) begin
        hsLat_r <= wb_dat_i[3:0];
      end
    end
  end

  // channel 0 is pair A; channel 1 is pair B, or A outbound in bidir
  assign chEnIn[0]  = (modeA == MODE_IN) || bidir;
  assign chEnOut[0] = modeA == MODE_OUT;
  assign chEnIn[1]  = (modeB == MODE_IN) && !bidir;
  // relies on software keeping port B bit-programmable here
  assign chEnOut[1] = ((modeB == MODE_OUT) && !bidir) || bidir;
  assign chStb[0]   = hsPin[`TPIO_HS_ASTB] == `TPIO_STB_ACTIVE;
  assign chStb[1]   = hsPin[`TPIO_HS_BSTB] == `TPIO_STB_ACTIVE;
  assign chDone[0]  = chEnIn[0] ? (rdEn & selA) : (wrEn & selA);
  assign chDone[1]  = bidir ? (wrEn & selA)
                    : (chEnIn[1] ? (rdEn & selB) : (wrEn & selB));

  // one sequencer per handshake channel
  for (genvar i = 0; i < 2; i++) begin : g_ch
    assign hs[i].enIn     = chEnIn[i];
    assign hs[i].enOut    = chEnOut[i];
    assign hs[i].stb      = chStb[i];
    assign hs[i].hostDone = chDone[i];
    assign chRdy[i]       = hs[i].rdy;
    assign chEvt[i]       = hs[i].evt;
    tpio_handshake u_hs (
      .clock (clock),
      .rst   (rstAll),
      .hs    (hs[i])
    );
  end

  // input buffers latch on the strobe trailing edge
  always_ff @(posedge clock) begin
    if (rstAll) begin
      aBuf_r <= '0;
      bBuf_r <= '0;
    end else begin
      if (chEvt[0] && chEnIn[0]) begin
        aBuf_r <= aPin;
      end
      if (chEvt[1] && chEnIn[1]) begin
        bBuf_r <= bPin;
      end
    end
  end

  // sticky events; a set in the clearing cycle survives
  assign statClr = (wrEn && wb_adr_i == `TPIO_ADR_ISTAT) ? wb_dat_i[1:0]
                                                         : 2'h0;
  always_ff @(posedge clock) begin
    if (rstAll) begin
      stat_r <= 2'h0;
    end else begin
      stat_r <= (stat_r & ~statClr) | chEvt;
    end
  end

  // interrupt outputs follow unmasked status one cycle later
  always_ff @(posedge clock) begin
    if (rstAll) begin
      intA_r <= 1'b0;
      intB_r <= 1'b0;
      irq_r  <= 1'b0;
    end else begin
      intA_r <= stat_r[0] & mask_r[0];
      intB_r <= stat_r[1] & mask_r[1];
      irq_r  <= |(stat_r & mask_r);
    end
  end
  assign intA = intA_r;
  assign intB = intB_r;
  assign irq  = irq_r;

  // port A data pins
  always_ff @(posedge clock) begin
    if (rstAll) begin
      aOut_r <= '0;
      aOeN_r <= '1;
    end else begin
      aOut_r <= aLat_r;
      case (modeA)
        MODE_IN:    aOeN_r <= '1;
        MODE_OUT:   aOeN_r <= '0;
        // bidir drives only while the outbound strobe is active
        MODE_BIDIR: aOeN_r <= {PW{~chStb[1]}};
        MODE_BITP:  aOeN_r <= ~aDir_r;
        default:    aOeN_r <= '1;
      endcase
    end
  end

  // port B data pins; bidir never applies here
  always_ff @(posedge clock) begin
    if (rstAll) begin
      bOut_r <= '0;
      bOeN_r <= '1;
    end else begin
      bOut_r <= bLat_r;
      case (modeB)
        MODE_IN:   bOeN_r <= '1;
        MODE_OUT:  bOeN_r <= '0;
        MODE_BITP: bOeN_r <= ~bDir_r;
        default:   bOeN_r <= '1;
      endcase
    end
  end

  // handshake pins: ready driven, strobe read, or general io
  always_ff @(posedge clock) begin
    if (rstAll) begin
      hsOut_r <= 4'h0;
      hsOeN_r <= 4'hf;
    end else begin
      hsOut_r[1:0] <= gp0 ? hsLat_r[1:0] : {1'b0, chRdy[0]};
      hsOut_r[3:2] <= gp1 ? hsLat_r[3:2] : {1'b0, chRdy[1]};
      hsOeN_r[1:0] <= gp0 ? ~hsDir_r[1:0] : 2'h2;
      hsOeN_r[3:2] <= gp1 ? ~hsDir_r[3:2] : 2'h2;
    end
  end
  // twenty controllable lines: two bytes and four handshakes
  assign aPinOut  = aOut_r;
  assign aPinOeN  = aOeN_r;
  assign bPinOut  = bOut_r;
  assign bPinOeN  = bOeN_r;
  assign hsPinOut = hsOut_r;
  assign hsPinOeN = hsOeN_r;

  // register readback; data reads depend on the port mode
  always_comb begin
    rdData = 32'h0;
    case (wb_adr_i)
      `TPIO_ADR_CTRL:  rdData = {28'h0, ctrl_r};
      `TPIO_ADR_ADIR:  rdData = {{(32-PW){1'b0}}, aDir_r};
      `TPIO_ADR_BDIR:  rdData = {{(32-PW){1'b0}}, bDir_r};
      `TPIO_ADR_HDIR:  rdData = {28'h0, hsDir_r};
      `TPIO_ADR_ADAT: begin
        if (chEnIn[0]) begin
          rdData = {{(32-PW){1'b0}}, aBuf_r};
        end else if (modeA == MODE_OUT) begin
          rdData = {{(32-PW){1'b0}}, aLat_r};
        end else begin
          rdData = {{(32-PW){1'b0}}, aPin};
        end
      end
      `TPIO_ADR_BDAT: begin
        if (chEnIn[1]) begin
          rdData = {{(32-PW){1'b0}}, bBuf_r};
        end else if (modeB == MODE_OUT) begin
          rdData = {{(32-PW){1'b0}}, bLat_r};
        end else begin
          rdData = {{(32-PW){1'b0}}, bPin};
        end
      end
      `TPIO_ADR_HDAT:  rdData = {28'h0, hsPin};
      `TPIO_ADR_ISTAT: rdData = {30'h0, stat_r};
      `TPIO_ADR_IMASK: rdData = {30'h0, mask_r};
      default:         rdData = 32'h0;
    endcase
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rstAll);

  clear_float_a: assert property (
    disable iff (rst) rstAll |=> (&{aOeN_r, bOeN_r, hsOeN_r}) && !irq_r)
    else $error("pins driven or irq high after clear");
  bmode_legal_a: assert property (modeB != MODE_BIDIR)
    else $error("port B in bidirectional mode");
  bidir_route_a: assert property (
    bidir |-> chEnIn[0] && chEnOut[1] && !chEnIn[1])
    else $error("bidir channel routing wrong");
  bit_dir_a: assert property (
    modeA == MODE_BITP |=> aOeN_r == ~$past(aDir_r))
    else $error("bit mode direction not applied");
  hs_general_a: assert property (
    gp1 |=> hsOeN_r[3:2] == ~$past(hsDir_r[3:2]))
    else $error("handshake general direction not applied");
  out_drive_a: assert property (
    modeB == MODE_OUT |=> bOeN_r == '0 && bOut_r == $past(bLat_r))
    else $error("output port not driving latch");
  buf_capture_a: assert property (
    chEvt[0] && chEnIn[0] |=> aBuf_r == $past(aPin) ##1 stat_r[0] ||
    $past(statClr[0]))
    else $error("input data not captured");
  irq_follow_a: assert property (
    chEvt[0] && mask_r[0] ##1 mask_r[0] && !statClr[0] |=> intA_r && irq_r)
    else $error("interrupt not raised after event");
  bus_ack_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle");
  bidir_c: cover property (bidir && chEvt[1]);
  in_irq_c: cover property (chEnIn[0] && chEvt[0] ##[1:4] intA_r);
  bit_mode_c: cover property (gp0 && gp1 && hsOeN_r != 4'hf);
endmodule : tpio_top

//--- tpio_periph.sv
// Purpose: peripheral model on the port and handshake pins
// Assumes: strobes active low, each pin resolved here from its oe
// Notes:   data no longer held is shown inverted, never stale
`timescale 1ns/1ns
module tpio_periph (
  input  wire logic       clock,
  input  wire logic [7:0] aPinOut,
  input  wire logic [7:0] aPinOeN,
  input  wire logic [7:0] bPinOut,
  input  wire logic [7:0] bPinOeN,
  input  wire logic [3:0] hsPinOut,
  input  wire logic [3:0] hsPinOeN,
  output logic      [7:0] aPinIn,
  output logic      [7:0] bPinIn,
  output logic      [3:0] hsPinIn
);
  logic [7:0] aExt = 8'h00;  // far-side drive, port a
  logic [7:0] bExt = 8'h00;  // far-side drive, port b
  logic [3:0] hsExt = 4'ha;  // strobes idle high, pull-up
  // device wins wherever its enable is low
  assign aPinIn = (~aPinOeN & aPinOut) | (aPinOeN & aExt);
  assign bPinIn = (~bPinOeN & bPinOut) | (bPinOeN & bExt);
  assign hsPinIn = (~hsPinOeN & hsPinOut) | (hsPinOeN & hsExt);
  // one strobe: p picks pair (0 a, 1 b), lo sets slow or prompt
  task automatic pulse(input bit p, input logic [7:0] d, input int lo);
    if (p) bExt <= d;
    else aExt <= d;
    repeat (2) @(posedge clock);
    hsExt[p ? 3 : 1] <= 1'b0;  // leading edge
    repeat (lo) @(posedge clock);
    hsExt[p ? 3 : 1] <= 1'b1;  // trailing edge
    repeat (5) @(posedge clock);  // hold past capture
    if (p) bExt <= ~d;
    else aExt <= ~d;  // hold over, so junk
  endtask : pulse
endmodule : tpio_periph

//--- test_two_port_programmable_io.sv
// Purpose: self-checking bench for the two-port io
// Assumes: classic wishbone, one ack per request
// Notes:   pins come from the peripheral model
`timescale 1ns/1ns
`include "tpio_params.svh"
module test_two_port_programmable_io;
  import tpio_pkg::*;
  logic        clock = 1'b0;   // 20 MHz
  logic        rst = 1'b1;     // sync reset
  logic        clearN = 1'b1;  // clear pin, idle high
  logic        wbCyc = 1'b0;   // bus cycle
  logic        wbStb = 1'b0;   // bus strobe
  logic        wbWe = 1'b0;    // write
  logic [7:0]  wbAdr = 8'h00;  // byte offset
  logic [3:0]  wbSel = 4'h0;   // lanes
  logic [31:0] wbDatW = 32'h0; // write data
  logic [31:0] wbDatR;         // read data
  logic        wbAck;          // answer
  logic [7:0]  aIn, aOut, aOeN, bIn, bOut, bOeN;  // port pins
  logic [3:0]  hsIn, hsOut, hsOeN;  // handshake pins
  logic        intA, intB, irq;     // interrupts
  int          n_mismatch = 0;      // failed compares
  int          total_checks = 0;    // compares made
  tpio_top #(.PW(8)) dut (
    .clock(clock), .rst(rst), .clearN(clearN),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
    .aPinIn(aIn), .aPinOut(aOut), .aPinOeN(aOeN),
    .bPinIn(bIn), .bPinOut(bOut), .bPinOeN(bOeN),
    .hsPinIn(hsIn), .hsPinOut(hsOut), .hsPinOeN(hsOeN),
    .intA(intA), .intB(intB), .irq(irq));
  tpio_periph p (
    .clock(clock), .aPinOut(aOut), .aPinOeN(aOeN),
    .bPinOut(bOut), .bPinOeN(bOeN), .hsPinOut(hsOut),
    .hsPinOeN(hsOeN), .aPinIn(aIn), .bPinIn(bIn), .hsPinIn(hsIn));
  // clock, half period 25 ns
  initial forever #25 clock = ~clock;
  // compare and count
  task automatic chk(input string s, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  // control word from the two modes
  function automatic logic [31:0] ctl(tpio_mode_t b, tpio_mode_t a);
    return {28'h0, b, a};
  endfunction : ctl
  // one classic cycle, held until ack is sampled high
  task automatic wb(input bit w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbSel <= 4'hf;
    wbDatW <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    q = wbDatR;
    chk("ack", 1, wbAck);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clock);  // stb low for one cycle at least
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string s, input logic [7:0] a,
                    input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(s, e, q);
  endtask : rd
  // reset state, unmapped place ignored
  task automatic t_reset();
    rd("ctrl", `TPIO_ADR_CTRL, 32'h0f);
    rd("mask", `TPIO_ADR_IMASK, 32'h03);
    chk("a oe", 32'hff, aOeN);
    chk("irq", 0, irq);
    wr(8'h24, 32'h00);
    rd("unmapped", 8'h24, 32'h0);
    rd("ctrl kept", `TPIO_ADR_CTRL, 32'h0f);
    $display("t_reset done");
  endtask : t_reset
  // per-line directions on all twenty lines
  task automatic t_bits();
    wr(`TPIO_ADR_ADIR, 32'h0f);
    wr(`TPIO_ADR_ADAT, 32'ha5);
    wr(`TPIO_ADR_BDIR, 32'hf0);
    wr(`TPIO_ADR_BDAT, 32'h5a);
    wr(`TPIO_ADR_HDIR, 32'h05);
    wr(`TPIO_ADR_HDAT, 32'h05);
    cyc(6);
    chk("a oe", 32'hf0, aOeN);
    chk("b oe", 32'h0f, bOeN);
    chk("hs oe", 32'ha, hsOeN);
    rd("a pins", `TPIO_ADR_ADAT, 32'h05);
    rd("b pins", `TPIO_ADR_BDAT, 32'h50);
    rd("hs pins", `TPIO_ADR_HDAT, 32'h0f);
    $display("t_bits done");
  endtask : t_bits
  // input on a, interrupt raised, masked, cleared
  task automatic t_in();
    wr(`TPIO_ADR_CTRL, ctl(MODE_BITP, MODE_IN));
    cyc(2);
    chk("a ready", 1, hsIn[0]);
    chk("a oe", 32'hff, aOeN);
    p.pulse(0, 8'h3c, 8);
    chk("a ready low", 0, hsIn[0]);
    repeat (10) if (intA !== 1'b1) @(posedge clock);
    chk("int a", 1, intA);
    chk("irq", 1, irq);
    rd("a buf", `TPIO_ADR_ADAT, 32'h3c);
    cyc(2);
    chk("a ready back", 1, hsIn[0]);
    rd("status", `TPIO_ADR_ISTAT, 32'h1);
    wr(`TPIO_ADR_IMASK, 32'h0);
    cyc(2);
    chk("masked", 0, intA);
    wr(`TPIO_ADR_IMASK, 32'h3);
    wr(`TPIO_ADR_ISTAT, 32'h1);
    cyc(2);
    chk("cleared", 0, irq);
    p.pulse(0, 8'h96, 3);
    repeat (10) if (intA !== 1'b1) @(posedge clock);
    rd("a buf 2", `TPIO_ADR_ADAT, 32'h96);
    wr(`TPIO_ADR_ISTAT, 32'h1);
    $display("t_in done");
  endtask : t_in
  // output on b, done on strobe trailing edge
  task automatic t_out();
    wr(`TPIO_ADR_CTRL, ctl(MODE_OUT, MODE_BITP));
    wr(`TPIO_ADR_BDAT, 32'h69);
    cyc(2);
    chk("b oe", 0, bOeN);
    chk("b out", 32'h69, bOut);
    chk("b ready", 1, hsIn[2]);
    p.pulse(1, 8'h00, 4);
    repeat (10) if (intB !== 1'b1) @(posedge clock);
    chk("int b", 1, intB);
    chk("b ready low", 0, hsIn[2]);
    wr(`TPIO_ADR_ISTAT, 32'h2);
    $display("t_out done");
  endtask : t_out
  // bidirectional a, b refused as bidir
  task automatic t_bidir();
    wr(`TPIO_ADR_CTRL, ctl(MODE_BIDIR, MODE_BITP));
    rd("b no bidir", `TPIO_ADR_CTRL, ctl(MODE_OUT, MODE_BITP));
    wr(`TPIO_ADR_CTRL, ctl(MODE_BITP, MODE_BIDIR));
    wr(`TPIO_ADR_ADAT, 32'hc5);
    cyc(2);
    chk("a idle", 32'hff, aOeN);
    chk("b ready", 1, hsIn[2]);
    fork
      p.pulse(1, 8'h00, 8);
      begin
        cyc(9);
        chk("a driven", 0, aOeN);
        chk("a out", 32'hc5, aIn);
      end
    join
    p.pulse(0, 8'h42, 6);
    repeat (10) if (intA !== 1'b1) @(posedge clock);
    rd("a in", `TPIO_ADR_ADAT, 32'h42);
    $display("t_bidir done");
  endtask : t_bidir
  // a output beside b input, both pairs idled first
  task automatic t_swap();
    wr(`TPIO_ADR_CTRL, ctl(MODE_BITP, MODE_BITP));
    wr(`TPIO_ADR_ISTAT, 32'h3);
    wr(`TPIO_ADR_CTRL, ctl(MODE_IN, MODE_OUT));
    cyc(2);
    chk("a not ready", 0, hsIn[0]);
    chk("b ready", 1, hsIn[2]);
    wr(`TPIO_ADR_ADAT, 32'h81);
    cyc(2);
    chk("a oe", 0, aOeN);
    chk("a drive", 32'h81, aIn);
    chk("a ready", 1, hsIn[0]);
    p.pulse(1, 8'h7e, 4);
    repeat (10) if (intB !== 1'b1) @(posedge clock);
    chk("int b", 1, intB);
    rd("b buf", `TPIO_ADR_BDAT, 32'h7e);
    // leave b in bit mode and status set, so the clear has work
    wr(`TPIO_ADR_CTRL, ctl(MODE_BITP, MODE_OUT));
    $display("t_swap done");
  endtask : t_swap
  // clear pin returns everything to reset
  task automatic t_clear();
    clearN <= 1'b0;
    cyc(6);
    clearN <= 1'b1;
    cyc(6);
    chk("a oe", 32'hff, aOeN);
    chk("b oe", 32'hff, bOeN);
    chk("hs oe", 32'hf, hsOeN);
    chk("irq", 0, irq);
    rd("ctrl", `TPIO_ADR_CTRL, 32'h0f);
    rd("a dir", `TPIO_ADR_ADIR, 32'h0);
    $display("t_clear done");
  endtask : t_clear
  // the one place the run ends
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // watchdog, run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_bits();
    t_in();
    t_out();
    t_bidir();
    t_swap();
    t_clear();
    wrap_up();
  end
endmodule : test_two_port_programmable_io
